// ### converter_fault_and_light_load_control.v
// Gate drive, dead time, light-load and supply supervision for a buck converter.
// Assumes the compensation loop supplies duty_command and reads reference_target.
`timescale 1ns/1ns
`include "converter_defines.vh"
module converter_fault_and_light_load_control #(
  parameter START_DELAY_CYCLES = `START_DELAY_CYC,
  parameter RAMP_CYCLES = `RAMP_CYC,
  parameter FAULT_DELAY_CYCLES = `FAULT_DELAY_CYC,
  parameter RETRY_DELAY_CYCLES = `RETRY_DELAY_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] duty_command,
  input wire [11:0] input_voltage_code,
  input wire [11:0] output_sense_input,
  input wire lockout_strap_high,
  input wire lockout_strap_low,
  input wire zero_current_detect,
  input wire single_phase,
  input wire share_group,
  input wire sync_autodetect,
  input wire ext_clock_present,
  input wire clock_out_enable,
  output reg high_side_gate_drive,
  output reg low_side_gate_drive,
  output reg power_good_output,
  output reg [11:0] reference_target
);
  localparam S_OFF = 7'h01;
  localparam S_DELAY = 7'h02;
  localparam S_RAMP = 7'h04;
  localparam S_RUN = 7'h08;
  localparam S_SHUT = 7'h10;
  localparam S_LATCH = 7'h20;
  localparam S_OVHOLD = 7'h40;

  function [15:0] merge;
    input [15:0] old;
    input [31:0] nw;
    input [1:0] strb;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [15:0] per_of;
    input [15:0] f;
    reg [31:0] p;
    begin
      p = `CLK_KHZ / {16'h0000, (f == 16'h0000) ? 16'h0001 : f};
      per_of = (p[31:16] != 16'h0000) ? 16'hffff : p[15:0];
    end
  endfunction

  function [15:0] afc_freq;
    input [15:0] fp;
    input [15:0] fm;
    input [15:0] d;
    input [15:0] dn;
    reg [33:0] t;
    begin
      t = ({18'h00000, fp - fm} << 1) * {18'h00000, d};
      t = t / {18'h00000, (dn == 16'h0000) ? 16'h0001 : dn};
      t = t + {18'h00000, fm};
      afc_freq = (t[33:16] != 18'h00000) ? fp : (t[15:0] & ~`AFC_STEP_MASK);
      if (afc_freq < fm)
        afc_freq = fm;
    end
  endfunction

  function [11:0] interp;
    input [11:0] st;
    input [11:0] tg;
    input [23:0] cnt;
    reg [35:0] t;
    begin
      t = {24'h000000, tg - st} * {12'h000, cnt};
      t = t / RAMP_CYCLES;
      interp = st + t[11:0];
    end
  endfunction

  reg [2:0] s1_reg, s2_reg, s3_reg, pin_reg;
  reg [1:0] ctrl_reg;
  reg misc_reg, restart_reg, lockout_written_reg, strap_done_reg;
  reg [2:0] strap_cnt_reg;
  reg [15:0] freq_reg, fmin_reg, dnom_reg, fault_reg, period_reg, cnt_reg, hs_w_reg;
  reg [11:0] lockout_reg, target_reg, prebias_reg;
  reg [6:0] state_reg;
  reg [23:0] timer_reg, flt_cnt_reg;
  reg [3:0] retry_left_reg;
  reg cause_ov_reg, cut_reg, dir_reg, uv_reg, ov_reg;
  reg [7:0] dead_reg;

  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

  wire uv_now = input_voltage_code < lockout_reg;
  wire [19:0] ov_prod = target_reg * fault_reg[`FLT_OVPCT];
  wire [19:0] ov_add = ov_prod / 20'h00064;
  wire [12:0] ov_thr = {1'b0, target_reg} + ov_add[12:0];
  wire ov_now = {1'b0, output_sense_input} > ov_thr;
  wire [1:0] uv_mode = fault_reg[`FLT_UVM];
  wire [1:0] ov_mode = ext_clock_present ? `OV_SHUT_AUTO : fault_reg[`FLT_OVM];
  wire drive_on = (state_reg == S_RAMP) | (state_reg == S_RUN);
  wire ls_force = state_reg == S_OVHOLD;
  wire de_active = (state_reg == S_RUN) & ctrl_reg[`CTRL_DE] & single_phase;
  wire afc_on = misc_reg & de_active & ~share_group & ~(sync_autodetect & ext_clock_present)
    & ~clock_out_enable;
  wire wrap = cnt_reg >= period_reg - 16'h0001;
  wire [15:0] hs_max = period_reg - {7'h00, dead_reg, 1'b0};
  // High side follows the loop; under falling load in diode emulation with AFC on the frequency drops
  wire [15:0] hs_w_next = (duty_command > hs_max) ? hs_max : duty_command;
  wire [16:0] hs_w2 = {hs_w_next, 1'b0};
  wire [15:0] f_next = (afc_on && hs_w2 < {1'b0, dnom_reg}) ?
    afc_freq(freq_reg, fmin_reg, hs_w_next, dnom_reg) : freq_reg;
  wire [15:0] ls_start = hs_w_reg + {8'h00, dead_reg};
  wire [15:0] ls_stop = period_reg - {8'h00, dead_reg};
  wire hs_on = drive_on & (cnt_reg < hs_w_reg);
  wire ls_on = ls_force | (drive_on & ~cut_reg & cnt_reg >= ls_start & cnt_reg < ls_stop);
  wire [11:0] strap_thr = pin_reg[0] ? `LOCKOUT_HIGH :
    (pin_reg[1] ? `LOCKOUT_LOW : `LOCKOUT_OPEN);
  wire [15:0] wmerged = merge(16'h0000, s_axi_wdata, s_axi_wstrb[1:0]);
  wire [15:0] tgt_merged = merge({4'h0, target_reg}, s_axi_wdata, s_axi_wstrb[1:0]);
  wire [11:0] lo_wr = wmerged[11:0];

  // Pins pass three flops; a level is taken only once the last two agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      pin_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {zero_current_detect, lockout_strap_low, lockout_strap_high};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (pin_reg & (s2_reg ^ s3_reg));
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= 2'h0;
      misc_reg <= 1'b0;
      restart_reg <= 1'b0;
      freq_reg <= `FREQ_RST;
      fmin_reg <= `FMIN_RST;
      dnom_reg <= `DNOM_RST;
      fault_reg <= `FAULT_RST;
      target_reg <= `TARGET_RST;
      lockout_reg <= `LOCKOUT_OPEN;
      lockout_written_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_cnt_reg <= 3'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      restart_reg <= 1'b0;
      // Strap is caught only after the synchroniser has filled
      if (!strap_done_reg)
      begin
        strap_cnt_reg <= strap_cnt_reg + 3'h1;
        if (strap_cnt_reg == 3'h4)
        begin
          strap_done_reg <= 1'b1;
          if (!lockout_written_reg)
            lockout_reg <= strap_thr;
        end
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (s_axi_awaddr)
          `OFS_CTRL:
          begin
            if (s_axi_wstrb[0])
            begin
              ctrl_reg <= s_axi_wdata[1:0];
              restart_reg <= s_axi_wdata[`CTRL_RESTART];
            end
          end
          `OFS_MISC: if (s_axi_wstrb[0]) misc_reg <= s_axi_wdata[`MISC_AFC];
          `OFS_FREQ: freq_reg <= merge(freq_reg, s_axi_wdata, s_axi_wstrb[1:0]);
          `OFS_FMIN: fmin_reg <= merge(fmin_reg, s_axi_wdata, s_axi_wstrb[1:0]);
          `OFS_DNOM: dnom_reg <= merge(dnom_reg, s_axi_wdata, s_axi_wstrb[1:0]);
          `OFS_FAULT: fault_reg <= merge(fault_reg, s_axi_wdata, s_axi_wstrb[1:0]);
          `OFS_TARGET: target_reg <= tgt_merged[11:0];
          `OFS_LOCKOUT:
          begin
            // Out-of-range writes are clamped rather than refused
            lockout_written_reg <= 1'b1;
            lockout_reg <= (lo_wr < `LOCKOUT_MIN) ? `LOCKOUT_MIN :
              ((lo_wr > `LOCKOUT_MAX) ? `LOCKOUT_MAX : lo_wr);
          end
          `OFS_STATUS, `OFS_PERIOD: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `OFS_CTRL: s_axi_rdata <= {30'h00000000, ctrl_reg};
          `OFS_MISC: s_axi_rdata <= {31'h00000000, misc_reg};
          `OFS_FREQ: s_axi_rdata <= {16'h0000, freq_reg};
          `OFS_FMIN: s_axi_rdata <= {16'h0000, fmin_reg};
          `OFS_DNOM: s_axi_rdata <= {16'h0000, dnom_reg};
          `OFS_LOCKOUT: s_axi_rdata <= {20'h00000, lockout_reg};
          `OFS_FAULT: s_axi_rdata <= {16'h0000, fault_reg};
          `OFS_TARGET: s_axi_rdata <= {20'h00000, target_reg};
          `OFS_STATUS: s_axi_rdata <= {9'h000, state_reg, dead_reg, 2'h0,
            state_reg == S_LATCH, afc_on, de_active, ov_reg, uv_reg, power_good_output};
          `OFS_PERIOD: s_axi_rdata <= {16'h0000, period_reg};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // Switching period, dead time and gate drive
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 16'h0000;
      period_reg <= per_of(`FREQ_RST);
      hs_w_reg <= 16'h0000;
      dead_reg <= `DT_RST;
      dir_reg <= 1'b0;
      cut_reg <= 1'b0;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
    end
    else
    begin
      if (wrap)
      begin
        cnt_reg <= 16'h0000;
        cut_reg <= 1'b0;
        hs_w_reg <= hs_w_next;
        period_reg <= per_of(f_next);
        // A wider pulse means the last dead-time step hurt, so turn back
        if (hs_w_next > hs_w_reg)
          dir_reg <= ~dir_reg;
        if (drive_on && hs_w_next != hs_w_reg)
        begin
          if ((dir_reg ^ (hs_w_next > hs_w_reg)) && dead_reg < `DT_MAX)
            dead_reg <= dead_reg + 8'h01;
          else if (!(dir_reg ^ (hs_w_next > hs_w_reg)) && dead_reg > `DT_MIN)
            dead_reg <= dead_reg - 8'h01;
        end
      end
      else
      begin
        cnt_reg <= cnt_reg + 16'h0001;
        if (de_active & pin_reg[2])
          cut_reg <= 1'b1;
      end
      high_side_gate_drive <= hs_on & ~ls_force;
      low_side_gate_drive <= ls_on & ~(hs_on & ~ls_force);
    end
  end

  // Start-up, pre-bias and fault sequencing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= S_OFF;
      timer_reg <= 24'h000000;
      flt_cnt_reg <= 24'h000000;
      retry_left_reg <= 4'h0;
      cause_ov_reg <= 1'b0;
      prebias_reg <= 12'h000;
      reference_target <= 12'h000;
      power_good_output <= 1'b0;
      uv_reg <= 1'b0;
      ov_reg <= 1'b0;
    end
    else
    begin
      uv_reg <= uv_now;
      ov_reg <= ov_now;
      if (!ctrl_reg[`CTRL_RUN])
      begin
        state_reg <= S_OFF;
        power_good_output <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_OFF:
          begin
            retry_left_reg <= fault_reg[`FLT_RETRY];
            timer_reg <= 24'h000000;
            flt_cnt_reg <= 24'h000000;
            state_reg <= S_DELAY;
          end
          S_DELAY:
          begin
            timer_reg <= timer_reg + 24'h000001;
            if (uv_now && uv_mode != `UV_CONTINUE)
              timer_reg <= 24'h000000;
            else if (timer_reg >= START_DELAY_CYCLES - 1)
            begin
              prebias_reg <= output_sense_input;
              timer_reg <= 24'h000000;
              if (ov_now)
              begin
                cause_ov_reg <= 1'b1;
                state_reg <= (ov_mode == `OV_LOW_HOLD) ? S_OVHOLD : S_SHUT;
              end
              else
              begin
                reference_target <= output_sense_input;
                state_reg <= S_RAMP;
              end
            end
          end
          S_RAMP, S_RUN:
          begin
            timer_reg <= timer_reg + 24'h000001;
            if (state_reg == S_RAMP)
            begin
              if (prebias_reg < target_reg)
                reference_target <= interp(prebias_reg, target_reg, timer_reg + 24'h000001);
              if (timer_reg >= RAMP_CYCLES - 1)
              begin
                state_reg <= S_RUN;
                power_good_output <= ~ov_now;
              end
            end
            else
            begin
              power_good_output <= ~ov_now;
              if (reference_target < target_reg)
                reference_target <= reference_target + 12'h001;
              else if (reference_target > target_reg)
                reference_target <= reference_target - 12'h001;
            end
            if (uv_now && uv_mode == `UV_DELAY_LATCH)
              flt_cnt_reg <= flt_cnt_reg + 24'h000001;
            else
              flt_cnt_reg <= 24'h000000;
            if (ov_now)
            begin
              power_good_output <= 1'b0;
              cause_ov_reg <= 1'b1;
              timer_reg <= 24'h000000;
              state_reg <= (ov_mode == `OV_LOW_HOLD) ? S_OVHOLD : S_SHUT;
            end
            else if (uv_now && uv_mode != `UV_CONTINUE)
            begin
              if (uv_mode != `UV_DELAY_LATCH)
              begin
                power_good_output <= 1'b0;
                cause_ov_reg <= 1'b0;
                timer_reg <= 24'h000000;
                state_reg <= S_SHUT;
              end
              else if (flt_cnt_reg >= FAULT_DELAY_CYCLES - 1)
              begin
                power_good_output <= 1'b0;
                state_reg <= S_LATCH;
              end
            end
          end
          S_SHUT:
          begin
            timer_reg <= timer_reg + 24'h000001;
            if (cause_ov_reg ? (ov_mode != `OV_RETRY) : (uv_mode != `UV_RETRY))
            begin
              if (!(cause_ov_reg ? ov_now : uv_now))
              begin
                timer_reg <= 24'h000000;
                state_reg <= S_DELAY;
              end
            end
            else if (timer_reg >= RETRY_DELAY_CYCLES - 1)
            begin
              timer_reg <= 24'h000000;
              if (retry_left_reg == 4'h0)
                state_reg <= S_LATCH;
              else
              begin
                retry_left_reg <= retry_left_reg - 4'h1;
                if (!(cause_ov_reg ? ov_now : uv_now))
                  state_reg <= S_DELAY;
              end
            end
          end
          S_OVHOLD:
          begin
            timer_reg <= timer_reg + 24'h000001;
            if (timer_reg >= RETRY_DELAY_CYCLES - 1)
            begin
              timer_reg <= 24'h000000;
              if (!ov_now)
                state_reg <= S_DELAY;
            end
          end
          S_LATCH:
          begin
            if (restart_reg)
              state_reg <= S_OFF;
          end
          default: state_reg <= S_OFF;
        endcase
      end
    end
  end
endmodule // converter_fault_and_light_load_control

// ### converter_defines.vh
// Constants for the converter fault and light-load control block.
// Assumes a 125 MHz aclk; all voltage codes are in 10 mV units.
`ifndef CONVERTER_DEFINES_VH
`define CONVERTER_DEFINES_VH
`define OFS_CTRL 6'h00
`define OFS_MISC 6'h04
`define OFS_FREQ 6'h08
`define OFS_FMIN 6'h0c
`define OFS_DNOM 6'h10
`define OFS_LOCKOUT 6'h14
`define OFS_FAULT 6'h18
`define OFS_TARGET 6'h1c
`define OFS_STATUS 6'h20
`define OFS_PERIOD 6'h24
`define CTRL_RUN 0
`define CTRL_DE 1
`define CTRL_RESTART 2
`define MISC_AFC 0
`define FLT_UVM 1:0
`define FLT_OVM 3:2
`define FLT_RETRY 7:4
`define FLT_OVPCT 15:8
`define FREQ_RST 16'h0190
`define FMIN_RST 16'h00c8
`define DNOM_RST 16'h0064
`define FAULT_RST 16'h0f00
`define TARGET_RST 12'h078
`define LOCKOUT_LOW 12'h12c
`define LOCKOUT_OPEN 12'h1c2
`define LOCKOUT_HIGH 12'h438
`define LOCKOUT_MIN 12'h11d
`define LOCKOUT_MAX 12'h640
`define UV_SHUT_AUTO 2'h0
`define UV_CONTINUE 2'h1
`define UV_DELAY_LATCH 2'h2
`define UV_RETRY 2'h3
`define OV_SHUT_AUTO 2'h0
`define OV_RETRY 2'h1
`define OV_LOW_HOLD 2'h2
`define DT_RST 8'h08
`define DT_MIN 8'h02
`define DT_MAX 8'h10
`define AFC_STEP_MASK 16'h000f
`define CLK_MHZ 32'h0000007d
`define CLK_KHZ 32'h0001e848
`define START_DELAY_US 32'h000003e8
`define RAMP_US 32'h000003e8
`define FAULT_DELAY_US 32'h00000064
`define RETRY_DELAY_US 32'h000003e8
`define START_DELAY_CYC (`START_DELAY_US * `CLK_MHZ)
`define RAMP_CYC (`RAMP_US * `CLK_MHZ)
`define FAULT_DELAY_CYC (`FAULT_DELAY_US * `CLK_MHZ)
`define RETRY_DELAY_CYC (`RETRY_DELAY_US * `CLK_MHZ)
`endif

// ### conv_stage_model.sv
// Power stage and output sense model for the converter bench.
// Assumes active high gate drives; the bench may force the output level.
`timescale 1ns/1ns
module conv_stage_model (
  input wire aclk,
  input wire hs,
  input wire ls,
  input wire [11:0] ref_level,
  input wire bias_on,
  input wire [11:0] bias_level,
  input wire light_load,
  output wire [11:0] sense,
  output reg zero_current
);
  reg [3:0] ls_run;
  // Ideal regulation: output sits on the reference unless held by an outside source
  assign sense = bias_on ? bias_level : ref_level;
  initial
  begin
    ls_run = 4'h0;
    zero_current = 1'b0;
  end
  // Light load: inductor current reaches zero a few cycles into the low side pulse
  always @(posedge aclk)
  begin
    ls_run <= ls ? ls_run + {3'h0, ls_run != 4'hf} : 4'h0;
    zero_current <= light_load && ls && ls_run >= 4'h3;
  end
endmodule // conv_stage_model

// ### conv_chk.sv
// Port checker for the converter control block.
// Assumes target and overvoltage percent stay at their reset values.
`timescale 1ns/1ns
module conv_chk #(
  parameter int OV_LIMIT = 138
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [11:0] output_sense_input,
  input wire high_side_gate_drive,
  input wire low_side_gate_drive,
  input wire power_good_output
);
  wire ov;
  assign ov = output_sense_input > OV_LIMIT;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  gates_apart_a: assert property (!(high_side_gate_drive && low_side_gate_drive))
    else $error("both gate drives on");
  ov_pg_drop_a: assert property (ov |-> ##[1:2] !power_good_output)
    else $error("power good held during overvoltage");
  ov_no_drive_a: assert property (ov [*4] |-> !high_side_gate_drive)
    else $error("high side driven during overvoltage");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ready_pair_a: assert property (s_axi_awready == s_axi_wready && !(s_axi_bvalid && s_axi_awready))
    else $error("write ready mismatch");
  cover property ($rose(power_good_output));
  cover property (ov ##1 !power_good_output);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // conv_chk

// ### converter_fault_and_light_load_control_tb_top.sv
// Top bench for the converter control block with its power stage model.
// Assumes the register map of the defines header; short delays.
`timescale 1ns/1ns
`include "converter_defines.vh"
module converter_fault_and_light_load_control_tb_top;
  reg aclk, aresetn, awv, wv, bready, arv, rready;
  reg st_hi, st_lo, single, share, bias_on, light;
  reg sync_auto, ext_clk, clk_out;
  reg [15:0] duty;
  reg [5:0] awaddr, araddr;
  reg [31:0] wdata, rdv;
  reg [3:0] wstrb;
  reg [1:0] rsp;
  reg [11:0] vin, bias;
  wire awr, wr_rdy, bv, arr, rv, hs, ls, pg, zcd;
  wire [1:0] br, rr;
  wire [31:0] rdata;
  wire [11:0] sense, refl;
  int err_total, total_checks, n, i, t;
  logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h190, 32'hc8, 32'h64, 32'h438, 32'hf00, 32'h78};
  converter_fault_and_light_load_control #(.START_DELAY_CYCLES(40), .RAMP_CYCLES(40),
    .FAULT_DELAY_CYCLES(20), .RETRY_DELAY_CYCLES(30)) u_converter_fault_and_light_load_control (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .duty_command(duty),
    .input_voltage_code(vin), .output_sense_input(sense), .lockout_strap_high(st_hi),
    .lockout_strap_low(st_lo), .zero_current_detect(zcd), .single_phase(single),
    .share_group(share), .sync_autodetect(sync_auto), .ext_clock_present(ext_clk),
    .clock_out_enable(clk_out), .high_side_gate_drive(hs), .low_side_gate_drive(ls),
    .power_good_output(pg), .reference_target(refl));
  conv_stage_model u_conv_stage_model (.aclk(aclk), .hs(hs), .ls(ls), .ref_level(refl),
    .bias_on(bias_on), .bias_level(bias), .light_load(light), .sense(sense), .zero_current(zcd));
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task complete_run;
  begin
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  function bit cond(input int w);
    case (w)
      0: cond = awr === 1'b1;
      1: cond = bv === 1'b1;
      2: cond = arr === 1'b1;
      3: cond = rv === 1'b1;
      4: cond = pg === 1'b1;
      default: cond = pg === 1'b0;
    endcase
  endfunction
  // Every wait is bounded; a hang ends the run as a mismatch
  task waitfor(input int w);
  begin
    n = 0;
    @(posedge aclk);
    while (!cond(w))
    begin
      n++;
      if (n > 3000)
      begin
        err_total++;
        $display("Error %0t: wait %0d too long", $time, w);
        complete_run;
      end
      @(posedge aclk);
    end
  end
  endtask
  // Ready is taken a cycle late so the held response is exercised
  task wr(input [5:0] a, input [31:0] d);
  begin
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    waitfor(0);
    awv <= 1'b0;
    wv <= 1'b0;
    @(posedge aclk);
    bready <= 1'b1;
    waitfor(1);
    rsp = br;
    bready <= 1'b0;
  end
  endtask
  task rd(input [5:0] a);
  begin
    araddr <= a;
    arv <= 1'b1;
    waitfor(2);
    arv <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    waitfor(3);
    rdv = rdata;
    rsp = rr;
    rready <= 1'b0;
  end
  endtask
  task rchk(input [5:0] a, input [31:0] m, input [31:0] e);
  begin
    rd(a);
    chk(rdv & m, e);
  end
  endtask
  task done;
  begin
    t++;
    $display("test %0d done", t);
  end
  endtask
  task fault_on(input uv);
  begin
    if (uv)
      vin <= 12'h0c8;
    else
      bias_on <= 1'b1;
  end
  endtask
  // Latching responses: stay off after the fault clears until restarted
  task latch(input [31:0] fw, input uv);
  begin
    wr(`OFS_FAULT, fw);
    fault_on(uv);
    repeat (5) @(posedge aclk);
    chk(pg, uv);
    waitfor(5);
    repeat (200) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h20, 32'h20);
    vin <= 12'h4b0;
    bias_on <= 1'b0;
    repeat (100) @(posedge aclk);
    chk(pg, 1'b0);
    wr(`OFS_CTRL, 32'h5);
    waitfor(4);
    done;
  end
  endtask
  initial
  begin
    {aresetn, awv, wv, bready, arv, rready, st_hi, st_lo, share, bias_on, light} = 11'h0;
    {awaddr, araddr, wdata, rdv, rsp, t} = 0;
    {err_total, total_checks, n} = 0;
    {sync_auto, ext_clk, clk_out} = 3'h0;
    duty = 16'h0028;
    single = 1'b1;
    wstrb = 4'hf;
    vin = 12'h4b0;
    bias = 12'h096;
    @(posedge aclk);
    for (i = 0; i < 3; i++)
    begin
      st_lo <= i == 1;
      st_hi <= i == 2;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
      rchk(`OFS_LOCKOUT, 32'hfff, i == 0 ? `LOCKOUT_OPEN : i == 1 ? `LOCKOUT_LOW : `LOCKOUT_HIGH);
    end
    for (i = 0; i < 8; i++)
      rchk(6'(i * 4), 32'hffffffff, rst_val[i]);
    rd(6'h28);
    chk(rsp, 2'h2);
    wr(6'h28, 32'h1);
    chk(rsp, 2'h2);
    wr(`OFS_LOCKOUT, 32'h10);
    rchk(`OFS_LOCKOUT, 32'hfff, `LOCKOUT_MIN);
    wr(`OFS_LOCKOUT, 32'hfff);
    rchk(`OFS_LOCKOUT, 32'hfff, `LOCKOUT_MAX);
    wr(`OFS_LOCKOUT, `LOCKOUT_OPEN);
    done;
    wr(`OFS_CTRL, 32'h1);
    waitfor(4);
    chk(refl, 12'h078);
    fault_on(1'b0);
    waitfor(5);
    repeat (4) @(posedge aclk);
    chk(hs, 1'b0);
    rchk(`OFS_STATUS, 32'h4, 32'h4);
    bias_on <= 1'b0;
    waitfor(4);
    fault_on(1'b1);
    waitfor(5);
    rchk(`OFS_STATUS, 32'h2, 32'h2);
    vin <= 12'h4b0;
    waitfor(4);
    wr(`OFS_FAULT, 32'hf01);
    fault_on(1'b1);
    repeat (80) @(posedge aclk);
    chk(pg, 1'b1);
    vin <= 12'h4b0;
    done;
    latch(32'hf02, 1'b1);
    latch(32'hf04, 1'b0);
    wr(`OFS_FAULT, 32'hf08);
    fault_on(1'b0);
    waitfor(5);
    repeat (4) @(posedge aclk);
    chk({hs, ls}, 2'h1);
    bias_on <= 1'b0;
    waitfor(4);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_FAULT, 32'hf00);
    bias <= 12'h082;
    bias_on <= 1'b1;
    wr(`OFS_CTRL, 32'h1);
    waitfor(4);
    chk(refl > 12'h078, 1'b1);
    repeat (30) @(posedge aclk);
    chk(refl, 12'h078);
    wr(`OFS_CTRL, 32'h0);
    bias <= 12'h096;
    wr(`OFS_CTRL, 32'h1);
    repeat (150) @(posedge aclk);
    chk(pg, 1'b0);
    rchk(`OFS_STATUS, 32'h4, 32'h4);
    bias_on <= 1'b0;
    waitfor(4);
    done;
    share <= 1'b1;
    single <= 1'b0;
    light <= 1'b1;
    wr(`OFS_CTRL, 32'h3);
    wr(`OFS_MISC, 32'h1);
    repeat (700) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h18, 32'h0);
    share <= 1'b0;
    single <= 1'b1;
    repeat (700) @(posedge aclk);
    rchk(`OFS_STATUS, 32'h18, 32'h18);
    rchk(`OFS_PERIOD, 32'hffff, 32'h163);
    n = 0;
    repeat (400) @(posedge aclk) n += ls;
    chk(n < 64, 1'b1);
    sync_auto <= 1'b1;
    ext_clk <= 1'b1;
    rchk(`OFS_STATUS, 32'h18, 32'h8);
    sync_auto <= 1'b0;
    clk_out <= 1'b1;
    rchk(`OFS_STATUS, 32'h18, 32'h8);
    clk_out <= 1'b0;
    wr(`OFS_FAULT, 32'hf08);
    fault_on(1'b0);
    waitfor(5);
    repeat (4) @(posedge aclk);
    chk({hs, ls}, 2'h0);
    bias_on <= 1'b0;
    waitfor(4);
    ext_clk <= 1'b0;
    wr(`OFS_MISC, 32'h0);
    rchk(`OFS_STATUS, 32'h10, 32'h0);
    repeat (400) @(posedge aclk);
    rchk(`OFS_PERIOD, 32'hffff, 32'h138);
    wr(`OFS_CTRL, 32'h1);
    done;
    complete_run;
  end
endmodule // converter_fault_and_light_load_control_tb_top
bind converter_fault_and_light_load_control conv_chk #(.OV_LIMIT(138)) u_conv_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .output_sense_input(output_sense_input),
  .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive),
  .power_good_output(power_good_output));
